//--- core/port_fg_alternate_function_mux.v
// override logic for the alternate functions of ports f and g
//==============================================================
// Operation
// - port f bits 7..0 feed converter channels 7..0, bits 7..4 also carry the test port.
// - with the test interface on, test data in, mode select and clock get forced pull-ups, test data out none.
// - with the test interface on, port f bits 7..4 lose direction and digital input control, and bit 6 also loses value control.
// - serial data on the test data input is passed to the instruction or data scan chain.
// - the test data output drives only in the instruction or data shift state.
// - test activity is timed by the test clock on port f bit 4.
// - port f bits 3..0 get no overrides and only feed converter channels 3..0.
// - timer 0 compare b drives port g bit 5 only when its direction bit is output.
// - port g bit 5 also carries the timer 0 channel b pwm output.
// - with async select set, port g bit 4 is the crystal amplifier input.
// - with async select and external clock select both set, port g bit 3 is the inverting amplifier output.
// - port g bit 2 carries the external memory address latch enable.
// - port g bit 1 carries the read strobe and bit 0 the write strobe.
// - with external memory enabled, port g bits 2..0 are outputs without pull-up.
//==============================================================
`include "port_fg_mux_defs.vh"

module port_fg_alternate_function_mux #(
   parameter W = `PORT_WIDTH
)(
   // clock and reset
   input  wire         core_clk_i,
   input  wire         rst_i,
   // port f registers from the core
   input  wire [W-1:0] pf_port_i,
   input  wire [W-1:0] pf_ddr_i,
   input  wire [W-1:0] pf_pullup_i,
   // port f pins
   input  wire [W-1:0] pf_pin_i,
   output reg  [W-1:0] pf_pin_o,
   output reg  [W-1:0] pf_pin_oe_n_o,
   output reg  [W-1:0] pf_pullup_o,
   output reg  [W-1:0] pf_din_o,
   output wire [W-1:0] analog_channel_o,
   // test port
   input  wire         test_interface_enable_i,
   input  wire         instr_shift_state_i,
   input  wire         data_shift_state_i,
   input  wire         tdo_value_i,
   output reg          tdi_sync_o,
   output reg          tms_sync_o,
   output reg          tck_sync_o,
   // port g registers from the core
   input  wire [W-1:0] pg_port_i,
   input  wire [W-1:0] pg_ddr_i,
   input  wire [W-1:0] pg_pullup_i,
   // port g pins
   input  wire [W-1:0] pg_pin_i,
   output reg  [W-1:0] pg_pin_o,
   output reg  [W-1:0] pg_pin_oe_n_o,
   output reg  [W-1:0] pg_pullup_o,
   output reg  [W-1:0] pg_din_o,
   // timer and external memory functions
   input  wire         timer0_compare_b_out_i,
   input  wire         timer0_compare_b_enable_i,
   input  wire         timer2_async_select_i,
   input  wire         ext_clock_select_i,
   input  wire         ext_mem_enable_i,
   input  wire         ext_mem_ale_i,
   input  wire         ext_mem_rd_i,
   input  wire         ext_mem_wr_i,
   output wire         timer_osc_enable_o
);

   //==============================================================
   // pin synchronisers
   reg [W-1:0] pf_meta;
   reg [W-1:0] pf_sync;
   reg [W-1:0] pg_meta;
   reg [W-1:0] pg_sync;

   // port f pads
   always @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         pf_meta <= `PORT_RESET_VAL;
         pf_sync <= `PORT_RESET_VAL;
      end
      else
      begin
         pf_meta <= pf_pin_i;
         pf_sync <= pf_meta;
      end
   end

   // port g pads
   always @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         pg_meta <= `PORT_RESET_VAL;
         pg_sync <= `PORT_RESET_VAL;
      end
      else
      begin
         pg_meta <= pg_pin_i;
         pg_sync <= pg_meta;
      end
   end

   // analog path is direct from the pad
   assign analog_channel_o = pf_pin_i;

   //==============================================================
   // override signal sets, one vector per kind and port
   // port f sets
   reg  [W-1:0] f_pu_en;
   reg  [W-1:0] f_pu_val;
   reg  [W-1:0] f_dir_en;
   reg  [W-1:0] f_dir_val;
   reg  [W-1:0] f_out_en;
   reg  [W-1:0] f_out_val;
   reg  [W-1:0] f_in_en;
   reg  [W-1:0] f_in_val;

   // port g sets
   reg  [W-1:0] g_pu_en;
   reg  [W-1:0] g_pu_val;
   reg  [W-1:0] g_dir_en;
   reg  [W-1:0] g_dir_val;
   reg  [W-1:0] g_out_en;
   reg  [W-1:0] g_out_val;
   reg  [W-1:0] g_in_en;
   reg  [W-1:0] g_in_val;
   wire         jt  = test_interface_enable_i;
   wire         sh  = instr_shift_state_i | data_shift_state_i;
   wire         osc = timer2_async_select_i;
   wire         xo  = timer2_async_select_i & ext_clock_select_i;
   wire         xm  = ext_mem_enable_i;

   assign timer_osc_enable_o = osc;

   //==============================================================
   // port f: test port on bits 7..4, nothing on 3..0
   always @*
   begin
      f_pu_en   = `PORT_RESET_VAL;
      f_pu_val  = `PORT_RESET_VAL;
      f_dir_en  = `PORT_RESET_VAL;
      f_dir_val = `PORT_RESET_VAL;
      f_out_en  = `PORT_RESET_VAL;
      f_out_val = `PORT_RESET_VAL;
      f_in_en   = `PORT_RESET_VAL;
      f_in_val  = `PORT_RESET_VAL;

      // test data input
      f_pu_en[`PF_TDI_BIT]  = jt;
      f_pu_val[`PF_TDI_BIT] = 1'b1;
      f_dir_en[`PF_TDI_BIT] = jt;
      f_in_en[`PF_TDI_BIT]  = jt;

      // test data output, no pull-up
      f_pu_en[`PF_TDO_BIT]   = jt;
      f_dir_en[`PF_TDO_BIT]  = jt;
      f_dir_val[`PF_TDO_BIT] = sh;
      f_out_en[`PF_TDO_BIT]  = jt;
      f_out_val[`PF_TDO_BIT] = tdo_value_i;
      f_in_en[`PF_TDO_BIT]   = jt;

      // test mode select
      f_pu_en[`PF_TMS_BIT]  = jt;
      f_pu_val[`PF_TMS_BIT] = 1'b1;
      f_dir_en[`PF_TMS_BIT] = jt;
      f_in_en[`PF_TMS_BIT]  = jt;

      // test clock
      f_pu_en[`PF_TCK_BIT]  = jt;
      f_pu_val[`PF_TCK_BIT] = 1'b1;
      f_dir_en[`PF_TCK_BIT] = jt;
      f_in_en[`PF_TCK_BIT]  = jt;
   end

   //==============================================================
   // port g: compare output, crystal pins, memory strobes
   always @*
   begin
      g_pu_en   = `PORT_RESET_VAL;
      g_pu_val  = `PORT_RESET_VAL;
      g_dir_en  = `PORT_RESET_VAL;
      g_dir_val = `PORT_RESET_VAL;
      g_out_en  = `PORT_RESET_VAL;
      g_out_val = `PORT_RESET_VAL;
      g_in_en   = `PORT_RESET_VAL;
      g_in_val  = `PORT_RESET_VAL;

      // compare b output, direction stays with the core
      g_out_en[`PG_CMP_B_BIT]  = timer0_compare_b_enable_i;
      g_out_val[`PG_CMP_B_BIT] = timer0_compare_b_out_i;

      // crystal amplifier input
      g_pu_en[`PG_OSC_IN_BIT]  = osc;
      g_dir_en[`PG_OSC_IN_BIT] = osc;
      g_in_en[`PG_OSC_IN_BIT]  = osc;
      g_in_val[`PG_OSC_IN_BIT] = ext_clock_select_i;

      // crystal amplifier output
      g_pu_en[`PG_OSC_OUT_BIT]  = xo;
      g_dir_en[`PG_OSC_OUT_BIT] = xo;
      g_in_en[`PG_OSC_OUT_BIT]  = xo;

      // address latch enable
      g_pu_en[`PG_ALE_BIT]   = xm;
      g_dir_en[`PG_ALE_BIT]  = xm;
      g_dir_val[`PG_ALE_BIT] = 1'b1;
      g_out_en[`PG_ALE_BIT]  = xm;
      g_out_val[`PG_ALE_BIT] = ext_mem_ale_i;

      // read strobe
      g_pu_en[`PG_RD_BIT]   = xm;
      g_dir_en[`PG_RD_BIT]  = xm;
      g_dir_val[`PG_RD_BIT] = 1'b1;
      g_out_en[`PG_RD_BIT]  = xm;
      g_out_val[`PG_RD_BIT] = ext_mem_rd_i;

      // write strobe
      g_pu_en[`PG_WR_BIT]   = xm;
      g_dir_en[`PG_WR_BIT]  = xm;
      g_dir_val[`PG_WR_BIT] = 1'b1;
      g_out_en[`PG_WR_BIT]  = xm;
      g_out_val[`PG_WR_BIT] = ext_mem_wr_i;
   end

   //==============================================================
   // per-pin selection, registered
   genvar i;
   generate
      for (i = 0; i < W; i = i + 1)
      begin : g_pin
         // port f picks
         wire f_dir = f_dir_en[i] ? f_dir_val[i] : pf_ddr_i[i];
         wire f_val = f_out_en[i] ? f_out_val[i] : pf_port_i[i];
         wire f_pu  = f_pu_en[i] ? f_pu_val[i] : (pf_pullup_i[i] & ~pf_ddr_i[i]);
         wire f_die = f_in_en[i] ? f_in_val[i] : 1'b1;
         // port g picks
         wire g_dir = g_dir_en[i] ? g_dir_val[i] : pg_ddr_i[i];
         wire g_val = g_out_en[i] ? g_out_val[i] : pg_port_i[i];
         wire g_pu  = g_pu_en[i] ? g_pu_val[i] : (pg_pullup_i[i] & ~pg_ddr_i[i]);
         wire g_die = g_in_en[i] ? g_in_val[i] : 1'b1;

         // port f drive and digital input
         always @(posedge core_clk_i or posedge rst_i)
         begin
            if (rst_i)
            begin
               pf_pin_o[i]      <= 1'b0;
               pf_pin_oe_n_o[i] <= 1'b1;
               pf_din_o[i]      <= 1'b0;
            end
            else
            begin
               pf_pin_o[i]      <= f_val;
               pf_pin_oe_n_o[i] <= ~f_dir;
               pf_din_o[i]      <= pf_sync[i] & f_die;
            end
         end

         // port f pull-ups ignore reset so test pins keep theirs
         always @(posedge core_clk_i)
         begin
            pf_pullup_o[i] <= f_pu;
         end

         // port g drive, pull-up and digital input
         always @(posedge core_clk_i or posedge rst_i)
         begin
            if (rst_i)
            begin
               pg_pin_o[i]      <= 1'b0;
               pg_pin_oe_n_o[i] <= 1'b1;
               pg_pullup_o[i]   <= 1'b0;
               pg_din_o[i]      <= 1'b0;
            end
            else
            begin
               pg_pin_o[i]      <= g_val;
               pg_pin_oe_n_o[i] <= ~g_dir;
               pg_pullup_o[i]   <= g_pu;
               pg_din_o[i]      <= pg_sync[i] & g_die;
            end
         end
      end
   endgenerate

   //==============================================================
   // test signals to the tap, sampled from synchronised pads
   always @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         tdi_sync_o <= 1'b0;
         tms_sync_o <= 1'b0;
         tck_sync_o <= 1'b0;
      end
      else
      begin
         tdi_sync_o <= jt & pf_sync[`PF_TDI_BIT];
         tms_sync_o <= jt & pf_sync[`PF_TMS_BIT];
         tck_sync_o <= jt & pf_sync[`PF_TCK_BIT];
      end
   end

endmodule // port_fg_alternate_function_mux

//--- core/port_fg_mux_defs.vh
// constants for the port f / port g alternate function override block
`ifndef PORT_FG_MUX_DEFS_VH
`define PORT_FG_MUX_DEFS_VH
`define PORT_WIDTH      8
`define PF_TDI_BIT      7
`define PF_TDO_BIT      6
`define PF_TMS_BIT      5
`define PF_TCK_BIT      4
`define PF_JTAG_MASK    8'hf0
`define PG_CMP_B_BIT    5
`define PG_OSC_IN_BIT   4
`define PG_OSC_OUT_BIT  3
`define PG_ALE_BIT      2
`define PG_RD_BIT       1
`define PG_WR_BIT       0
`define PG_XMEM_MASK    8'h07
`define PG_OSC_MASK     8'h18
`define PG_CMP_B_MASK   8'h20
`define PORT_RESET_VAL  8'h00
`endif

//--- tb/port_fg_mux_properties.sv
// assertions for the port f and g override block
//====
// checker
module port_fg_mux_checker(
   input wire logic       core_clk_i, rst_i, test_interface_enable_i, instr_shift_state_i,
   input wire logic       data_shift_state_i, tdo_value_i, timer0_compare_b_out_i,
   input wire logic       timer0_compare_b_enable_i, timer2_async_select_i, ext_clock_select_i,
   input wire logic       ext_mem_enable_i, ext_mem_ale_i, ext_mem_rd_i, ext_mem_wr_i, timer_osc_enable_o,
   input wire logic [7:0] pf_ddr_i, pf_pin_i, pf_pin_o, pf_pin_oe_n_o, pf_pullup_o, analog_channel_o,
   input wire logic [7:0] pg_ddr_i, pg_pin_o, pg_pin_oe_n_o, pg_pullup_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (rst_i);
   wire       te = test_interface_enable_i;
   wire       sh = instr_shift_state_i | data_shift_state_i;
   wire [2:0] xm = {ext_mem_ale_i, ext_mem_rd_i, ext_mem_wr_i};
   property p_tdo_on; te && sh |=> !pf_pin_oe_n_o[6] && pf_pin_o[6] == $past(tdo_value_i); endproperty
   a_tdo_on: assert property (p_tdo_on) else $error("tdo not driven");
   property p_tdo_off; te && !sh |=> pf_pin_oe_n_o[6]; endproperty
   a_tdo_off: assert property (p_tdo_off) else $error("tdo driven");
   property p_test_pu; te |=> pf_pullup_o[7:4] == 4'hb; endproperty
   a_test_pu: assert property (p_test_pu) else $error("test pullups");
   property p_test_dir; te |=> pf_pin_oe_n_o[7] && pf_pin_oe_n_o[5] && pf_pin_oe_n_o[4]; endproperty
   a_test_dir: assert property (p_test_dir) else $error("test pin driven");
   property p_direct; analog_channel_o == pf_pin_i && timer_osc_enable_o == timer2_async_select_i; endproperty
   a_direct: assert property (p_direct) else $error("direct path");
   property p_low_nib; 1'b1 |=> pf_pin_oe_n_o[3:0] == ~$past(pf_ddr_i[3:0]); endproperty
   a_low_nib: assert property (p_low_nib) else $error("low nibble dir");
   property p_cmp_b; pg_ddr_i[5] && timer0_compare_b_enable_i |=> !pg_pin_oe_n_o[5]
      && pg_pin_o[5] == $past(timer0_compare_b_out_i); endproperty
   a_cmp_b: assert property (p_cmp_b) else $error("compare b");
   property p_osc_in; timer2_async_select_i |=> pg_pin_oe_n_o[4] && !pg_pullup_o[4]; endproperty
   a_osc_in: assert property (p_osc_in) else $error("osc in");
   property p_osc_out; timer2_async_select_i && ext_clock_select_i |=> pg_pin_oe_n_o[3] && !pg_pullup_o[3];
   endproperty
   a_osc_out: assert property (p_osc_out) else $error("osc out");
   property p_xmem; ext_mem_enable_i |=> pg_pin_oe_n_o[2:0] == 3'h0 && pg_pullup_o[2:0] == 3'h0
      && pg_pin_o[2:0] == $past(xm); endproperty
   a_xmem: assert property (p_xmem) else $error("ext mem");
endmodule // port_fg_mux_checker
bind port_fg_alternate_function_mux port_fg_mux_checker u_port_fg_mux_checker(.*);

//--- tb/pad_far_side.sv
// far side pads: pullups, host drive, floating lines
module pad_far_side(
   input  wire logic       clk_i,
   input  wire logic [7:0] out_i, oe_n_i, pull_i, drv_en_i, drv_i,
   output wire logic [7:0] pin_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] last = 8'h00;
   always @(posedge clk_i) last <= pin_o;
   // host drives data in, select and clock lines, a floating line toggles
   assign pin_o = ~oe_n_i & out_i | oe_n_i & (drv_en_i & drv_i | ~drv_en_i & (pull_i | ~last));
endmodule // pad_far_side

//--- tb/port_fg_alternate_function_mux_tb.sv
// bench for the port f and g override block
module port_fg_alternate_function_mux_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic       core_clk_i = 0, rst_i = 1;
   logic [7:0] pf_port_i, pf_ddr_i, pf_pullup_i, pg_port_i, pg_ddr_i, pg_pullup_i, hdrv, hen;
   wire  [7:0] pf_pin_i, pg_pin_i, pf_pin_o, pf_pin_oe_n_o, pf_pullup_o, pf_din_o, analog_channel_o;
   wire  [7:0] pg_pin_o, pg_pin_oe_n_o, pg_pullup_o, pg_din_o;
   logic       test_interface_enable_i, instr_shift_state_i, data_shift_state_i, tdo_value_i;
   logic       timer0_compare_b_out_i, timer0_compare_b_enable_i, timer2_async_select_i, ext_clock_select_i;
   logic       ext_mem_enable_i, ext_mem_ale_i, ext_mem_rd_i, ext_mem_wr_i;
   wire        tdi_sync_o, tms_sync_o, tck_sync_o, timer_osc_enable_o;
   int         n_mismatch = 0, samples_checked = 0, cyc = 0;
   port_fg_alternate_function_mux u_port_fg_alternate_function_mux(.*);
   pad_far_side u_pf_pads(.clk_i(core_clk_i), .out_i(pf_pin_o), .oe_n_i(pf_pin_oe_n_o), .pull_i(pf_pullup_o),
      .drv_en_i(hen), .drv_i(hdrv), .pin_o(pf_pin_i));
   pad_far_side u_pg_pads(.clk_i(core_clk_i), .out_i(pg_pin_o), .oe_n_i(pg_pin_oe_n_o), .pull_i(pg_pullup_o),
      .drv_en_i(8'h00), .drv_i(8'h00), .pin_o(pg_pin_i));
   always #2 core_clk_i = ~core_clk_i;
   always @(posedge core_clk_i) if (++cyc == 2000)
   begin
      n_mismatch++;
      summarize;
   end
   //====
   // tasks
   task tick(input int n);
      repeat (n) @(posedge core_clk_i);
      #1;
   endtask
   task chk(input string n, input logic [7:0] e, g);
      samples_checked++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("unexpected %s exp %h got %h", n, e, g);
      end
   endtask
   task summarize;
      if (n_mismatch == 0 && samples_checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   //====
   // tests
   initial
   begin
      {pf_port_i, pf_ddr_i, pf_pullup_i, pg_port_i, pg_ddr_i, pg_pullup_i, hdrv, hen} = '0;
      {test_interface_enable_i, instr_shift_state_i, data_shift_state_i, tdo_value_i} = '0;
      {timer0_compare_b_out_i, timer0_compare_b_enable_i, timer2_async_select_i, ext_clock_select_i} = '0;
      {ext_mem_enable_i, ext_mem_ale_i, ext_mem_rd_i, ext_mem_wr_i} = '0;
      tick(12);
      chk("pf_oe_n", 8'hff, pf_pin_oe_n_o);
      @(posedge core_clk_i);
      rst_i <= 0;
      pf_port_i <= 8'ha5;
      pf_ddr_i <= 8'h0f;
      pf_pullup_i <= 8'hf0;
      tick(4);
      chk("pf_oe_n", 8'hf0, pf_pin_oe_n_o);
      chk("pf_pull", 8'hf0, pf_pullup_o);
      chk("pf_out", 8'h05, pf_pin_o & 8'h0f);
      chk("analog", 8'hf5, analog_channel_o);
      chk("pf_din", 8'hf5, pf_din_o);
      @(posedge core_clk_i);
      test_interface_enable_i <= 1;
      pf_ddr_i <= 8'hff;
      hen <= 8'hb0;
      hdrv <= 8'h90;
      tick(4);
      chk("pf_oe_n", 8'hf0, pf_pin_oe_n_o);
      chk("pf_pull", 8'hb0, pf_pullup_o);
      chk("pf_din", 8'h05, pf_din_o);
      chk("tap", 8'h05, {5'h00, tdi_sync_o, tms_sync_o, tck_sync_o});
      for (int k = 0; k < 4; k++)
      begin
         @(posedge core_clk_i);
         {tdo_value_i, instr_shift_state_i, data_shift_state_i} <= {k[1], k[0], ~k[0]};
         tick(2);
         chk("tdo", {6'h00, 1'b0, k[1]}, {6'h00, pf_pin_oe_n_o[6], pf_pin_o[6]});
      end
      @(posedge core_clk_i);
      {instr_shift_state_i, data_shift_state_i} <= 2'h0;
      pg_ddr_i <= 8'h20;
      {timer0_compare_b_enable_i, timer0_compare_b_out_i} <= 2'h3;
      tick(2);
      chk("tdo_oe_n", 8'h01, {7'h00, pf_pin_oe_n_o[6]});
      chk("pg_oc", 8'h20, pg_pin_o & 8'h20);
      @(posedge core_clk_i);
      pg_ddr_i <= 8'h08;
      pg_pullup_i <= 8'h10;
      {timer2_async_select_i, ext_clock_select_i} <= 2'h3;
      tick(2);
      chk("pg_oe_n", 8'hff, pg_pin_oe_n_o);
      chk("pg_pull", 8'h00, pg_pullup_o);
      chk("osc_en", 8'h01, {7'h00, timer_osc_enable_o});
      chk("pg_din", 8'h00, pg_din_o & 8'h08);
      @(posedge core_clk_i);
      ext_mem_enable_i <= 1;
      pg_pullup_i <= 8'h07;
      for (int v = 2; v < 8; v += 3)
      begin
         @(posedge core_clk_i);
         {ext_mem_ale_i, ext_mem_rd_i, ext_mem_wr_i} <= v[2:0];
         tick(2);
         chk("pg_xmem", {5'h1f, 3'h0} | v[7:0], pg_pin_oe_n_o & 8'hf8 | pg_pin_o & 8'h07);
         chk("pg_pull", 8'h00, pg_pullup_o);
      end
      @(posedge core_clk_i);
      rst_i <= 1;
      tick(2);
      chk("pf_pull", 8'hb0, pf_pullup_o);
      chk("pf_oe_n", 8'hff, pf_pin_oe_n_o);
      summarize;
   end
endmodule // port_fg_alternate_function_mux_tb
